// ==== include/cca_meas_if.sv ====
/*
  Link between the channel check controller and its measurement window.
  Assumes both ends run on the same clock.
*/
interface cca_meas_if;
  logic start;          // Open a window, one-cycle pulse
  logic energy_hit;     // Energy above threshold this cycle
  logic carrier_hit;    // Carrier detected this cycle
  logic done;           // Window ended, one-cycle pulse
  logic energy_seen;    // Energy found during the window
  logic carrier_seen;   // Carrier found during the window
  modport ctrl (output start, energy_hit, carrier_hit,
                input done, energy_seen, carrier_seen);
  modport meas (input start, energy_hit, carrier_hit,
                output done, energy_seen, carrier_seen);
endinterface

// ==== include/cca_pkg.sv ====
/*
  Constants, register map and decision functions of the channel check block.
  Assumes one 250 MHz system clock shared by every user of this package.
*/
package cca_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] CCA_ADDR_STATUS  = 8'h01;  // Read-only state/status
  localparam logic [7:0] CCA_ADDR_CTRL    = 8'h08;  // Trigger, method, channel
  localparam logic [7:0] CCA_ADDR_THRES   = 8'h09;  // Energy threshold
  localparam logic [7:0] CCA_CTRL_RESET   = 8'h2b;  // Method 1, channel 11
  localparam logic [7:0] ENERGY_THRESHOLD_REGISTER_RESET  = 8'hc7;  // Threshold field 0x7
  localparam logic [7:0] CHANNEL_IDLE_FLAG_RESET = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int CCA_BIT_TRIGGER  = 7;   // Control: trigger
  localparam int CCA_BIT_METH_HI  = 6;   // Control: method field 6:5
  localparam int CCA_BIT_METH_LO  = 5;
  localparam int CCA_BIT_CHAN_HI  = 4;   // Control: channel field 4:0
  localparam int CCA_BIT_COMPLETE = 7;   // Status: completion flag
  localparam int CCA_BIT_IDLE     = 6;   // Status: idle/busy flag

  // ==========================================================================
  // Method encodings
  localparam logic [1:0] CCA_METH_CS_OR  = 2'h0;
  localparam logic [1:0] CCA_METH_ENERGY = 2'h1;
  localparam logic [1:0] CCA_METH_CS     = 2'h2;
  localparam logic [1:0] CCA_METH_CS_AND = 2'h3;

  // ==========================================================================
  // Timing
  localparam int CCA_CLK_MHZ        = 250;  // Cycles per microsecond
  localparam int CCA_SYMBOL_US      = 16;   // One symbol period
  localparam int CCA_MEAS_US        = 128;  // Eight symbol periods
  localparam int CCA_RESULT_MAX_US  = 180;  // Latest readable result
  localparam int CCA_MEAS_CYCLES    = CCA_MEAS_US * CCA_CLK_MHZ;
  localparam int CCA_SHORT_CYCLES   = 2 * CCA_SYMBOL_US * CCA_CLK_MHZ;
  localparam int CCA_RESULT_CYCLES  = CCA_RESULT_MAX_US * CCA_CLK_MHZ;

  // Energy busy when level exceeds twice the threshold (2 dB per step)
  function automatic logic cca_energy_busy(input logic [7:0] level,
                                           input logic [3:0] thres);
    return level > {3'h0, thres, 1'b0};
  endfunction

  // Combine carrier and energy findings by method; returns busy
  function automatic logic cca_channel_busy(input logic [1:0] meth,
                                            input logic cs, input logic eb);
    logic b;
    b = 1'b0;
    unique case (meth)
      CCA_METH_CS_OR:  b = cs | eb;
      CCA_METH_ENERGY: b = eb;
      CCA_METH_CS:     b = cs;
      CCA_METH_CS_AND: b = cs & eb;
    endcase
    return b;
  endfunction

endpackage

// ==== rtl/cca_meas.sv ====
/*
  Fixed-length measurement window that gathers energy and carrier hits.
  Assumes hits are sampled on clk_sys and start is ignored while running.
*/
module cca_meas
  import cca_pkg::*;
#(
  parameter int MEAS_CYCLES = CCA_MEAS_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Controller side
  cca_meas_if.meas m
);

  localparam int CW = $clog2(MEAS_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(MEAS_CYCLES - 1);

  logic          run_r;   // Window open
  logic [CW-1:0] cnt_r;   // Cycles elapsed in window
  logic          done_r;  // End pulse
  logic          eng_r;   // Energy accumulated
  logic          car_r;   // Carrier accumulated

  // ==========================================================================
  // Window timing
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      run_r <= 1'b0;
      cnt_r <= '0;
    end else if (m.start && !run_r) begin
      run_r <= 1'b1;
      cnt_r <= '0;
    end else if (run_r) begin
      // Full window of eight symbol periods
      run_r <= (cnt_r != LAST);
      cnt_r <= cnt_r + CW'(1);
    end
  end

  // End pulse
  always_ff @(posedge clk_sys) begin
    if (rst) done_r <= 1'b0;
    else     done_r <= run_r && (cnt_r == LAST);
  end

  // ==========================================================================
  // Any hit in the window makes the finding sticky until next start
  always_ff @(posedge clk_sys) begin
    if (rst || (m.start && !run_r)) begin
      eng_r <= 1'b0;
      car_r <= 1'b0;
    end else if (run_r) begin
      eng_r <= eng_r | m.energy_hit;
      car_r <= car_r | m.carrier_hit;
    end
  end

  assign m.done         = done_r;
  assign m.energy_seen  = eng_r;
  assign m.carrier_seen = car_r;

  // Window stays open for at least eight cycles after a start
  property p_window_len;
    @(posedge clk_sys) disable iff (rst)
      (m.start && !run_r) |=> run_r [*8];
  endproperty
  a_window_len : assert property (p_window_len)
    else $error("measurement window closed early");

endmodule // cca_meas

// ==== rtl/cca_top.sv ====
/*
  Clear channel assessment: control/threshold registers, status flags,
  manual measurement sequencing and the automated per-frame energy window.
  Assumes the register port, receiver state and detector inputs all come
  from logic on clk_sys, so none of them is synchronised here.
*/
// How it works
// - Trigger write starts check in receive state
// - Eight-symbol window, result within 180 us
// - Every manual check pulses the done interrupt
// - Energy busy above twice threshold field
// - Trigger clears completion and idle flags
// - Completion set; idle flag reflects outcome
// - OR and carrier methods report busy on carrier; AND also needs energy
// - Method field selects OR/energy/carrier/AND
// - Invalid state still completes, no measurement
// - Trigger bit self-clears, reads zero
// - Busy receive: method 2 immediate, others wait for a running window
// - One automated energy window per frame
// - Host measures in listen; preamble detect off
// - Read-only status layout, resets zero
// - Control layout, reset method 1 channel 11
// - Threshold bits 3:0, reset 0x7
module cca_top
  import cca_pkg::*;
#(
  parameter int MEAS_CYCLES   = CCA_MEAS_CYCLES,   // Eight symbol window
  parameter int SHORT_CYCLES  = CCA_SHORT_CYCLES,  // Two symbol window
  parameter int RESULT_CYCLES = CCA_RESULT_CYCLES  // Latest result
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Register port
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Transceiver state
  input  wire logic [4:0] transceiver_state,
  input  wire logic       basic_mode,
  input  wire logic       rx_listen,
  input  wire logic       rx_busy,
  input  wire logic       high_rate,
  // Detectors
  input  wire logic [7:0] energy_level_result,
  input  wire logic       carrier_detect,
  input  wire logic       shr_detect,
  // Outputs
  output logic            measure_done_event,
  output logic      [4:0] channel_number
);

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,  // Waiting for trigger
    ST_START   = 2'b01,  // Flags cleared, choose path
    ST_LISTEN  = 2'b10,  // Window running in listen state
    ST_WAIT_ED = 2'b11   // Waiting for automated energy window
  } cca_state_t;

  localparam int AW = $clog2(MEAS_CYCLES + 1);
  localparam int LW = $clog2(RESULT_CYCLES + 2);

  cca_meas_if mi ();

  cca_state_t    state_r, state_nxt;  // Sequencer
  logic    [7:0] ctrl_r;              // Method and channel, bit 7 unused
  logic    [7:0] thres_r;             // Threshold register
  logic          complete_r;          // Completion flag
  logic          idle_r;              // Idle/busy flag
  logic          irq_r;               // Done interrupt pulse
  logic    [7:0] rdata_r;             // Read data
  logic          req_ok_r;            // Request valid at trigger time
  logic          req_listen_r;        // Request made in listen state
  logic          auto_run_r;          // Automated window running
  logic          auto_used_r;         // Frame already measured
  logic          auto_hit_r;          // Automated window energy finding
  logic          auto_end_r;          // Automated window end pulse
  logic [AW-1:0] auto_cnt_r;          // Automated window counter
  logic [AW-1:0] auto_last_r;         // Length of running window - 1
  logic          fin, fin_busy;       // Finish now, with busy outcome
  logic          trig_wr;             // Accepted trigger write
  logic          energy_now;          // Energy above threshold now
  logic [LW-1:0] lat_r;               // Request age, checked below

  assign energy_now = cca_energy_busy(energy_level_result, thres_r[3:0]);
  // Triggers during a running check are ignored
  assign trig_wr = reg_wr && (reg_addr == CCA_ADDR_CTRL)
                   && reg_wdata[CCA_BIT_TRIGGER] && (state_r == ST_IDLE);

  assign mi.energy_hit  = energy_now;
  assign mi.carrier_hit = carrier_detect;
  assign mi.start       = (state_r == ST_START) && req_ok_r && req_listen_r;

  cca_meas #(.MEAS_CYCLES(MEAS_CYCLES)) u_meas (
    .clk_sys (clk_sys),
    .rst     (rst),
    .m       (mi)
  );

  // ==========================================================================
  // Register writes; the trigger bit is never stored
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_r  <= CCA_CTRL_RESET;
      thres_r <= ENERGY_THRESHOLD_REGISTER_RESET;
    end else if (reg_wr) begin
      if (reg_addr == CCA_ADDR_CTRL)
        ctrl_r <= {1'b0, reg_wdata[6:0]};
      if (reg_addr == CCA_ADDR_THRES)
        thres_r <= reg_wdata;
    end
  end

  assign channel_number = ctrl_r[CCA_BIT_CHAN_HI:0];

  // Registered read data; unmapped addresses read zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        CCA_ADDR_STATUS: rdata_r <= {complete_r, idle_r, 1'b0, transceiver_state};
        CCA_ADDR_CTRL:   rdata_r <= {1'b0, ctrl_r[6:0]};
        CCA_ADDR_THRES:  rdata_r <= thres_r;
        default:         rdata_r <= 8'h00;
      endcase
    end
  end

  assign reg_rdata = rdata_r;

  // ==========================================================================
  // Capture request conditions at the trigger write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      req_ok_r     <= 1'b0;
      req_listen_r <= 1'b0;
    end else if (trig_wr) begin
      // Extended mode or non-receive state gives an empty check
      req_ok_r     <= basic_mode && (rx_listen || rx_busy);
      // Listen state gets the full eight-symbol window
      req_listen_r <= rx_listen;
    end
  end

  // ==========================================================================
  // Automated energy window, once per frame after sync header
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      auto_run_r  <= 1'b0;
      auto_used_r <= 1'b0;
      auto_hit_r  <= 1'b0;
      auto_end_r  <= 1'b0;
      auto_cnt_r  <= '0;
      auto_last_r <= '0;
    end else begin
      auto_end_r <= 1'b0;
      if (!rx_busy) begin
        auto_used_r <= 1'b0;  // Frame over, rearm
        auto_run_r  <= 1'b0;
      end else if (shr_detect && !auto_used_r) begin
        auto_used_r <= 1'b1;
        auto_run_r  <= 1'b1;
        auto_hit_r  <= energy_now;
        auto_cnt_r  <= '0;
        auto_last_r <= high_rate ? AW'(SHORT_CYCLES - 1) : AW'(MEAS_CYCLES - 1);
      end else if (auto_run_r) begin
        auto_hit_r <= auto_hit_r | energy_now;
        auto_cnt_r <= auto_cnt_r + AW'(1);
        if (auto_cnt_r == auto_last_r) begin
          auto_run_r <= 1'b0;
          auto_end_r <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Sequencer decisions
  always_comb begin
    state_nxt = state_r;
    fin       = 1'b0;
    fin_busy  = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (trig_wr) state_nxt = ST_START;
      end
      ST_START: begin
        if (!req_ok_r) begin
          fin       = 1'b1;
          fin_busy  = 1'b1;
          state_nxt = ST_IDLE;
        end else if (req_listen_r) begin
          state_nxt = ST_LISTEN;
        end else if (ctrl_r[6:5] == CCA_METH_CS) begin
          fin       = 1'b1;
          fin_busy  = carrier_detect;
          state_nxt = ST_IDLE;
        end else if (auto_run_r) begin
          state_nxt = ST_WAIT_ED;
        end else begin
          fin       = 1'b1;
          fin_busy  = cca_channel_busy(ctrl_r[6:5], carrier_detect, auto_hit_r);
          state_nxt = ST_IDLE;
        end
      end
      ST_LISTEN: begin
        if (mi.done) begin
          fin       = 1'b1;
          fin_busy  = cca_channel_busy(ctrl_r[6:5], mi.carrier_seen, mi.energy_seen);
          state_nxt = ST_IDLE;
        end
      end
      ST_WAIT_ED: begin
        // Frame may end before the window; finish with what was gathered
        if (auto_end_r || !auto_run_r) begin
          fin       = 1'b1;
          fin_busy  = cca_channel_busy(ctrl_r[6:5], carrier_detect, auto_hit_r);
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) state_r <= ST_IDLE;
    else     state_r <= state_nxt;
  end

  // ==========================================================================
  // Status flags and interrupt; triggers only land in idle, so never collide
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      complete_r <= CHANNEL_IDLE_FLAG_RESET[CCA_BIT_COMPLETE];
      idle_r     <= CHANNEL_IDLE_FLAG_RESET[CCA_BIT_IDLE];
      irq_r      <= 1'b0;
    end else begin
      irq_r <= fin;
      if (trig_wr) begin
        complete_r <= 1'b0;
        idle_r     <= 1'b0;
      end else if (fin) begin  // Set once, then held to next trigger
        complete_r <= 1'b1;
        idle_r     <= !fin_busy;
      end
    end
  end

  assign measure_done_event = irq_r;

  // Request age for the latency check
  always_ff @(posedge clk_sys) begin
    if (rst || state_r == ST_IDLE) lat_r <= '0;
    else                           lat_r <= lat_r + LW'(1);
  end

  // ==========================================================================
  // Checks
  property p_clear;
    @(posedge clk_sys) disable iff (rst)
      trig_wr |=> !complete_r && !idle_r;
  endproperty
  a_clear : assert property (p_clear)
    else $error("flags not cleared by trigger");

  property p_irq;
    @(posedge clk_sys) disable iff (rst)
      $rose(complete_r) |-> measure_done_event ##1 !measure_done_event;
  endproperty
  a_irq : assert property (p_irq)
    else $error("done interrupt not one pulse at completion");

  property p_reject;
    @(posedge clk_sys) disable iff (rst)
      (trig_wr && !basic_mode) |-> ##2 complete_r && !idle_r && measure_done_event;
  endproperty
  a_reject : assert property (p_reject)
    else $error("invalid request not completed");

  property p_trig_reads_zero;
    @(posedge clk_sys) disable iff (rst)
      (reg_rd && reg_addr == CCA_ADDR_CTRL) |=> !reg_rdata[CCA_BIT_TRIGGER];
  endproperty
  a_trig_reads_zero : assert property (p_trig_reads_zero)
    else $error("trigger bit read back as one");

  property p_latency;
    @(posedge clk_sys) disable iff (rst)
      lat_r <= LW'(RESULT_CYCLES);
  endproperty
  a_latency : assert property (p_latency)
    else $error("result later than allowed");

  property p_hold;
    @(posedge clk_sys) disable iff (rst)
      (complete_r && !trig_wr) |=> $stable(complete_r) && $stable(idle_r);
  endproperty
  a_hold : assert property (p_hold)
    else $error("status flags changed without trigger");

  property p_method2_fast;
    @(posedge clk_sys) disable iff (rst)
      (trig_wr && basic_mode && rx_busy && !rx_listen
       && reg_wdata[CCA_BIT_METH_HI:CCA_BIT_METH_LO] == CCA_METH_CS) |-> ##2 complete_r;
  endproperty
  a_method2_fast : assert property (p_method2_fast)
    else $error("carrier-only check not immediate");

  property p_status_read;
    @(posedge clk_sys) disable iff (rst)
      (reg_rd && reg_addr == CCA_ADDR_STATUS) |=>
        reg_rdata == {$past(complete_r), $past(idle_r), 1'b0, $past(transceiver_state)};
  endproperty
  a_status_read : assert property (p_status_read)
    else $error("status register layout wrong");

endmodule // cca_top

// ==== tb/cca_host_model.sv ====
/*
  Host side model: issues register writes and reads on the device port.
  Assumes one clock shared with the device; requests change 1 ns after an edge.
*/
module cca_host_model (
  // Clock
  input  wire logic       clk_sys,
  // Register port towards the device
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Idle bus
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'hff;
    reg_wdata = 8'h00;
  end

  // One write; data is inverted afterwards so stale data never looks valid
  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_sys);
    #1;
    reg_addr  = addr;
    reg_wdata = data;
    reg_wr    = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = 8'hff;
    reg_wdata = ~data;
  endtask

  // One read; data is registered, so it is settled after the taking edge
  task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk_sys);
    #1;
    reg_addr = addr;
    reg_rd   = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_rd   = 1'b0;
    reg_addr = 8'hff;
    data     = reg_rdata;
  endtask

  // Check request: issued in both basic and extended mode by the bench
  task automatic trigger(input logic [1:0] meth, input logic [4:0] chan);
    reg_write(8'h08, {1'b1, meth, chan});
  endtask
endmodule // cca_host_model

// ==== tb/cca_top_tb.sv ====
/*
  Self-checking bench for the channel check block, scenario tasks and verdict.
  Assumes the host model for register traffic and short window parameters.
*/
module cca_top_tb
  import cca_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Shortened counts, keeps the run small
  localparam int MEAS = 12;
  localparam int RES  = 20;

  logic       clk_sys;             // System clock
  logic       rst;                 // Synchronous reset
  logic       reg_wr;              // Register strobes and data
  logic       reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [4:0] state;               // Transceiver state code
  logic       basic_mode;          // Receiver condition levels
  logic       rx_listen;
  logic       rx_busy;
  logic       high_rate;
  logic [7:0] level;               // Energy level, 1 dB steps
  logic       carrier;             // Carrier detector
  logic       shr;                 // Sync header pulse
  logic       done_irq;            // Done interrupt
  logic [4:0] chan;                // Channel number output
  logic [7:0] d;                   // Last read value
  int         n;                   // Cycles waited for done
  int         bad_count;           // Mismatches
  int         checks;              // Comparisons

  // ==========================================================================
  // Instances
  cca_top #(.MEAS_CYCLES(MEAS), .SHORT_CYCLES(4), .RESULT_CYCLES(RES)) i_cca_top (
    .clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .transceiver_state(state), .basic_mode(basic_mode), .rx_listen(rx_listen),
    .rx_busy(rx_busy), .high_rate(high_rate), .energy_level_result(level),
    .carrier_detect(carrier), .shr_detect(shr), .measure_done_event(done_irq),
    .channel_number(chan));

  cca_host_model i_cca_host_model (
    .clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // Compare, wait and verdict helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Status byte as the bench predicts it
  function automatic logic [7:0] st(input logic c, input logic i);
    return {c, i, 1'b0, state};
  endfunction

  // Wait for the done pulse, then it must drop after one cycle
  task automatic done_wait(input int lim);
    n = 0;
    while (done_irq !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk({7'h0, done_irq}, 8'h01);
    @(posedge clk_sys);
    #1;
    chk({7'h0, done_irq}, 8'h00);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    i_cca_host_model.reg_read(CCA_ADDR_STATUS, d);
    chk(d, st(1'b0, 1'b0));
    i_cca_host_model.reg_read(CCA_ADDR_CTRL, d);
    chk(d, 8'h2b);
    i_cca_host_model.reg_read(CCA_ADDR_THRES, d);
    chk(d, 8'hc7);
    i_cca_host_model.reg_read(8'h3c, d);
    chk(d, 8'h00);
    chk({3'h0, chan}, 8'h0b);
    $display("test reset values done");
  endtask

  task automatic t_regs;
    i_cca_host_model.reg_write(CCA_ADDR_CTRL, 8'h7f);
    i_cca_host_model.reg_read(CCA_ADDR_CTRL, d);
    chk(d, 8'h7f);
    chk({3'h0, chan}, 8'h1f);
    i_cca_host_model.reg_write(CCA_ADDR_THRES, 8'h05);
    i_cca_host_model.reg_read(CCA_ADDR_THRES, d);
    chk(d, 8'h05);
    i_cca_host_model.reg_write(CCA_ADDR_STATUS, 8'hff);
    i_cca_host_model.reg_read(CCA_ADDR_STATUS, d);
    chk(d, st(1'b0, 1'b0));
    $display("test register access done");
  endtask

  // Trigger outside basic mode, or outside receive states, completes unmeasured
  task automatic t_invalid;
    for (int v = 0; v < 2; v++) begin
      basic_mode = v[0];
      rx_listen  = ~v[0];
      i_cca_host_model.trigger(2'h2, 5'h15);
      done_wait(3);
      i_cca_host_model.reg_read(CCA_ADDR_STATUS, d);
      chk(d, st(1'b1, 1'b0));
    end
    i_cca_host_model.reg_read(CCA_ADDR_CTRL, d);
    chk(d, 8'h55);
    basic_mode = 1'b1;
    $display("test invalid state done");
  endtask

  // Every method against every carrier/energy pair, at the 2 dB boundary
  task automatic t_methods;
    logic busy;
    rx_listen = 1'b1;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 4; k++) begin
        carrier = k[0];
        level   = k[1] ? 8'h0b : 8'h0a;                    // Threshold 5
        case (m)
          0: busy = k[0] | k[1];
          1: busy = k[1];
          2: busy = k[0];
          default: busy = k[0] & k[1];
        endcase
        i_cca_host_model.trigger(m[1:0], 5'h0b);
        i_cca_host_model.reg_read(CCA_ADDR_STATUS, d);
        chk(d, st(1'b0, 1'b0));
        done_wait(RES);
        i_cca_host_model.reg_read(CCA_ADDR_STATUS, d);
        chk(d, st(1'b1, ~busy));
      end
    end
    $display("test methods done");
  endtask

  // Busy receive: waits for the frame window, then answers at once
  task automatic t_busy;
    rx_listen = 1'b0;
    rx_busy   = 1'b1;
    carrier   = 1'b1;
    level     = 8'h40;
    shr       = 1'b1;
    @(posedge clk_sys);
    #1;
    shr = 1'b0;
    i_cca_host_model.trigger(2'h1, 5'h0b);
    done_wait(MEAS + 4);
    chk({7'h0, n > 3}, 8'h01);
    i_cca_host_model.trigger(2'h2, 5'h0b);
    done_wait(3);
    i_cca_host_model.reg_read(CCA_ADDR_STATUS, d);
    chk(d, st(1'b1, 1'b0));
    shr = 1'b1;
    @(posedge clk_sys);
    #1;
    shr = 1'b0;
    i_cca_host_model.trigger(2'h3, 5'h0b);
    done_wait(3);
    i_cca_host_model.reg_read(CCA_ADDR_STATUS, d);
    chk(d, st(1'b1, 1'b0));
    // Frame over; the next frame in high-rate mode gets the short window
    rx_busy = 1'b0;
    @(posedge clk_sys);
    #1;
    rx_busy   = 1'b1;
    high_rate = 1'b1;
    level     = 8'h00;
    shr       = 1'b1;
    @(posedge clk_sys);
    #1;
    shr = 1'b0;
    i_cca_host_model.trigger(2'h1, 5'h0b);
    done_wait(MEAS + 4);
    chk({7'h0, n > 1 && n < 6}, 8'h01);
    i_cca_host_model.reg_read(CCA_ADDR_STATUS, d);
    chk(d, st(1'b1, 1'b1));
    rx_busy   = 1'b0;
    high_rate = 1'b0;
    $display("test busy receive done");
  endtask

  // Reset in mid-check drops the check; the block restarts cleanly after it
  task automatic t_rerun;
    rx_listen = 1'b1;
    i_cca_host_model.trigger(2'h1, 5'h0b);
    repeat (3) @(posedge clk_sys);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    chk({7'h0, done_irq}, 8'h00);
    i_cca_host_model.reg_read(CCA_ADDR_STATUS, d);
    chk(d, st(1'b0, 1'b0));
    i_cca_host_model.reg_read(CCA_ADDR_THRES, d);
    chk(d, ENERGY_THRESHOLD_REGISTER_RESET);
    i_cca_host_model.trigger(2'h1, 5'h0b);
    done_wait(RES);
    i_cca_host_model.reg_read(CCA_ADDR_STATUS, d);
    chk(d, st(1'b1, 1'b1));
    rx_listen = 1'b0;
    $display("test mid-run reset done");
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    bad_count  = 0;
    checks     = 0;
    rst        = 1'b1;
    state      = 5'h16;
    basic_mode = 1'b1;
    rx_listen  = 1'b0;
    rx_busy    = 1'b0;
    high_rate  = 1'b0;
    level      = 8'h00;
    carrier    = 1'b0;
    shr        = 1'b0;
    repeat (12) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    t_reset();
    t_regs();
    t_invalid();
    t_methods();
    t_busy();
    t_rerun();
    results();
  end

  // Run needs under 1500 cycles; a hang is cut well beyond that
  initial begin
    repeat (6000) @(posedge clk_sys);
    bad_count++;
    results();
  end
endmodule // cca_top_tb
